// [gst_timer.sv]
// Gated sixteen-bit timer with AXI4-Lite register access
// Contract
// - Sixteen-bit up count, read and written as high and low bytes.
// - Off when on bit clear; free running or gated per gate enable.
// - Clock select: 11 osc, 10 pin, 01 system, 00 system/4.
// - System clock source advances four counts per instruction cycle.
// - External source counts pin rising edges, synchronised or not.
// - External rising edge counts only after a falling edge was seen.
// - Prescaler divides selected clock by 1, 2, 4 or 8.
// - Prescale counter hidden from software, cleared by count writes.
// - Sync disable lets external counting run through sleep and wake.
// - Mode switch may drop or add one increment.
// - Byte reads always valid; overflow between byte reads possible.
// - Gated mode counts only while gate active, else holds.
// - Polarity bit picks active gate level.
// - Gate source: 0 gate pin, 1 companion timer wrap pulse.
// - Companion wrap pulse feeds the gate logic internally.
// - Toggle mode flip-flop toggles per active-going gate edge, cleared while toggle mode off.
// - Single pulse armed by go, counts one gate pulse, clears go.
// - After go clears, further gate events are ignored.
// - Toggle plus single pulse counts one full gate source cycle.
// - Gate level readable as status, even with gating off.
// - Falling gate level sets gate event flag, even with gating off.
// - Count wrap from FFFF to 0000 sets overflow flag.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gst_timer (
	input wire logic clk,
	input wire logic resetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic external_clock_pin,
	input wire logic external_gate_pin,
	input wire logic low_freq_internal_osc,
	input wire logic companion_timer_wrap_pulse,
	input wire logic sleep,
	output logic overflow_flag,
	output logic gate_event_flag,
	output logic wake
);
	import gst_pkg::*;

	// Bus slave state
	logic aw_got_q, w_got_q;
	logic [7:0] waddr_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic do_write;
	logic wr_lo, wr_hi, wr_tctl, wr_gctl, wr_flag, wr_cnt;
	logic w_mapped, r_mapped;
	logic [7:0] rd_byte;

	// Timer state
	logic [15:0] cnt_q;
	gst_tctl_s tctl_q;
	gst_gctl_s gctl_q;
	logic ovf_q, gev_q, wake_q;
	logic [1:0] phase_q;
	logic [2:0] presc_q;
	logic [2:0] presc_last;
	logic src_tick, pre_tick, inc, cnt_en, run_ok;

	// Pin synchronisers and edge history
	logic ck_s1_q, ck_s2_q, ck_d_q;
	logic gt_s1_q, gt_s2_q;
	logic lf_s1_q, lf_s2_q, lf_d_q;
	logic ck_rise, ck_fall, lf_rise;
	logic ext_armed_q, ext_pend_q, ext_tick;

	// Gate path
	logic gate_raw, gate_act, gate_act_d_q, gate_act_rise;
	logic tog_q, gate_sel, gate_sel_d_q, sel_rise, sel_fall;
	logic sp_q, gate_level, gval_q, gval_fall;

	// Bus write channel: address and data taken in either order
	assign do_write = aw_got_q && w_got_q && !bvalid_q;
	assign w_mapped = (waddr_q == GST_ADDR_CNT_LO) || (waddr_q == GST_ADDR_CNT_HI) ||
		(waddr_q == GST_ADDR_TCTL) || (waddr_q == GST_ADDR_GCTL) ||
		(waddr_q == GST_ADDR_FLAG);
	assign wr_lo = do_write && wlane_q && (waddr_q == GST_ADDR_CNT_LO);
	assign wr_hi = do_write && wlane_q && (waddr_q == GST_ADDR_CNT_HI);
	assign wr_tctl = do_write && wlane_q && (waddr_q == GST_ADDR_TCTL);
	assign wr_gctl = do_write && wlane_q && (waddr_q == GST_ADDR_GCTL);
	assign wr_flag = do_write && wlane_q && (waddr_q == GST_ADDR_FLAG);
	assign wr_cnt = wr_lo || wr_hi;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			aw_got_q <= 1'b0;
			awready_q <= 1'b1;
			waddr_q <= 8'h00;
		end else if (awvalid && awready_q) begin
			aw_got_q <= 1'b1;
			awready_q <= 1'b0;
			waddr_q <= {awaddr[7:2], 2'h0};
		end else if (do_write) begin
			aw_got_q <= 1'b0;
		end else if (bvalid_q && bready) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			w_got_q <= 1'b0;
			wready_q <= 1'b1;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
		end else if (wvalid && wready_q) begin
			w_got_q <= 1'b1;
			wready_q <= 1'b0;
			wbyte_q <= wdata[7:0];
			wlane_q <= wstrb[0];
		end else if (do_write) begin
			w_got_q <= 1'b0;
		end else if (bvalid_q && bready) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= GST_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= w_mapped ? GST_RESP_OKAY : GST_RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read mux; all state is in the clk domain, so a byte read is never torn
	always_comb begin
		r_mapped = 1'b1;
		rd_byte = 8'h00;
		case ({araddr[7:2], 2'h0})
			GST_ADDR_CNT_LO: rd_byte = cnt_q[7:0];
			GST_ADDR_CNT_HI: rd_byte = cnt_q[15:8];
			GST_ADDR_TCTL: begin
				rd_byte[GST_TCTL_CS_LSB +: 2] = tctl_q.cs;
				rd_byte[GST_TCTL_PS_LSB +: 2] = tctl_q.ps;
				rd_byte[GST_TCTL_SYNCDIS] = tctl_q.sync_dis;
				rd_byte[GST_TCTL_ON] = tctl_q.on;
			end
			GST_ADDR_GCTL: begin
				rd_byte[GST_GCTL_GE] = gctl_q.ge;
				rd_byte[GST_GCTL_POL] = gctl_q.pol;
				rd_byte[GST_GCTL_TM] = gctl_q.tm;
				rd_byte[GST_GCTL_SPM] = gctl_q.spm;
				rd_byte[GST_GCTL_GO] = gctl_q.go;
				rd_byte[GST_GCTL_VAL] = gval_q;
				rd_byte[GST_GCTL_GSS_LSB +: 2] = gctl_q.gss;
			end
			GST_ADDR_FLAG: begin
				rd_byte[GST_FLAG_GEV] = gev_q;
				rd_byte[GST_FLAG_OVF] = ovf_q;
			end
			default: r_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= GST_RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= {24'h00_0000, rd_byte};
			rresp_q <= r_mapped ? GST_RESP_OKAY : GST_RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Control registers
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tctl_q <= gst_tctl_s'(GST_TCTL_RST[7:2]);
		end else if (wr_tctl) begin
			tctl_q.cs <= wbyte_q[GST_TCTL_CS_LSB +: 2];
			tctl_q.ps <= wbyte_q[GST_TCTL_PS_LSB +: 2];
			tctl_q.sync_dis <= wbyte_q[GST_TCTL_SYNCDIS];
			tctl_q.on <= wbyte_q[GST_TCTL_ON];
		end
	end

	// Software write of go wins over the hardware clear in the same cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gctl_q <= gst_gctl_s'(GST_GCTL_RST[6:0]);
		end else if (wr_gctl) begin
			gctl_q.ge <= wbyte_q[GST_GCTL_GE];
			gctl_q.pol <= wbyte_q[GST_GCTL_POL];
			gctl_q.tm <= wbyte_q[GST_GCTL_TM];
			gctl_q.spm <= wbyte_q[GST_GCTL_SPM];
			gctl_q.go <= wbyte_q[GST_GCTL_GO];
			gctl_q.gss <= wbyte_q[GST_GCTL_GSS_LSB +: 2];
		end else if (gctl_q.spm && sp_q && sel_fall) begin
			gctl_q.go <= 1'b0;
		end
	end

	// Pin synchronisers; only the second stage feeds logic
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			ck_d_q <= 1'b0;
			gt_s1_q <= 1'b0;
			gt_s2_q <= 1'b0;
			lf_s1_q <= 1'b0;
			lf_s2_q <= 1'b0;
			lf_d_q <= 1'b0;
		end else begin
			ck_s1_q <= external_clock_pin;
			ck_s2_q <= ck_s1_q;
			ck_d_q <= ck_s2_q;
			gt_s1_q <= external_gate_pin;
			gt_s2_q <= gt_s1_q;
			lf_s1_q <= low_freq_internal_osc;
			lf_s2_q <= lf_s1_q;
			lf_d_q <= lf_s2_q;
		end
	end

	assign ck_rise = ck_s2_q && !ck_d_q;
	assign ck_fall = !ck_s2_q && ck_d_q;
	assign lf_rise = lf_s2_q && !lf_d_q;

	// A rising edge counts only once a falling edge has been seen
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ext_armed_q <= 1'b0;
		end else if (wr_cnt || !tctl_q.on) begin
			ext_armed_q <= 1'b0;
		end else if (ck_fall) begin
			ext_armed_q <= 1'b1;
		end
	end

	// Synchronous mode holds an edge until the instruction cycle boundary;
	// changing sync_dis mid-flight can drop or add one edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ext_pend_q <= 1'b0;
		end else if (tctl_q.sync_dis || wr_cnt || phase_q == GST_INSTR_LAST) begin
			ext_pend_q <= 1'b0;
		end else if (ck_rise && ext_armed_q) begin
			ext_pend_q <= 1'b1;
		end
	end

	always_comb begin
		if (tctl_q.sync_dis) begin
			ext_tick = ck_rise && ext_armed_q;
		end else begin
			ext_tick = (phase_q == GST_INSTR_LAST) && (ext_pend_q || (ck_rise && ext_armed_q));
		end
	end

	// Instruction clock phase, free running
	always_ff @(posedge clk) begin
		if (!resetn) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	always_comb begin
		case (tctl_q.cs)
			GST_CS_INSTR: src_tick = (phase_q == GST_INSTR_LAST);
			GST_CS_SYS: src_tick = 1'b1;
			GST_CS_EXT: src_tick = ext_tick;
			GST_CS_LFOSC: src_tick = lf_rise;
			default: src_tick = 1'b0;
		endcase
	end

	// Gate source, polarity, toggle and single pulse
	assign gate_raw = (gctl_q.gss == GST_GSS_COMP) ? companion_timer_wrap_pulse : gt_s2_q;
	assign gate_act = gctl_q.pol ? gate_raw : !gate_raw;
	assign gate_act_rise = gate_act && !gate_act_d_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			gate_act_d_q <= 1'b0;
			tog_q <= 1'b0;
		end else begin
			gate_act_d_q <= gate_act;
			if (!gctl_q.tm) begin
				tog_q <= 1'b0;
			end else if (gate_act_rise) begin
				tog_q <= !tog_q;
			end
		end
	end

	assign gate_sel = gctl_q.tm ? tog_q : gate_act;
	assign sel_rise = gate_sel && !gate_sel_d_q;
	assign sel_fall = !gate_sel && gate_sel_d_q;

	// Pulse window opens on the first gate edge after go, closes at its end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gate_sel_d_q <= 1'b0;
			sp_q <= 1'b0;
		end else begin
			gate_sel_d_q <= gate_sel;
			if (!gctl_q.spm || sel_fall) begin
				sp_q <= 1'b0;
			end else if (sel_rise && gctl_q.go) begin
				sp_q <= 1'b1;
			end
		end
	end

	assign gate_level = gctl_q.spm ? sp_q : gate_sel;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			gval_q <= 1'b0;
		end else begin
			gval_q <= gate_level;
		end
	end

	assign gval_fall = !gval_q && gate_level ? 1'b0 : (gval_q && !gate_level);

	// Count enable and prescaler
	assign run_ok = !sleep || (tctl_q.cs == GST_CS_EXT && tctl_q.sync_dis);
	assign cnt_en = tctl_q.on && (!gctl_q.ge || gate_level) && run_ok;

	always_comb begin
		case (tctl_q.ps)
			2'h0: presc_last = 3'h0;
			2'h1: presc_last = 3'h1;
			2'h2: presc_last = 3'h3;
			default: presc_last = 3'h7;
		endcase
	end

	assign pre_tick = src_tick && cnt_en && (presc_q == presc_last);
	assign inc = pre_tick && !wr_cnt;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			presc_q <= 3'h0;
		end else if (wr_cnt) begin
			presc_q <= 3'h0;
		end else if (src_tick && cnt_en) begin
			presc_q <= (presc_q == presc_last) ? 3'h0 : presc_q + 3'h1;
		end
	end

	// Count; a byte write takes priority over a coinciding increment
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_q <= GST_CNT_RST;
		end else if (wr_lo) begin
			cnt_q[7:0] <= wbyte_q;
		end else if (wr_hi) begin
			cnt_q[15:8] <= wbyte_q;
		end else if (inc) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// Flags: hardware set wins over a write-one clear
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ovf_q <= 1'b0;
			gev_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			if (inc && cnt_q == GST_CNT_MAX) begin
				ovf_q <= 1'b1;
			end else if (wr_flag && wbyte_q[GST_FLAG_OVF]) begin
				ovf_q <= 1'b0;
			end
			if (gval_fall) begin
				gev_q <= 1'b1;
			end else if (wr_flag && wbyte_q[GST_FLAG_GEV]) begin
				gev_q <= 1'b0;
			end
			wake_q <= sleep && inc && cnt_q == GST_CNT_MAX;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign overflow_flag = ovf_q;
	assign gate_event_flag = gev_q;
	assign wake = wake_q;

	sequence cnt_quiet_s;
		!wr_cnt;
	endsequence

	sequence sp_open_s;
		gctl_q.spm && gctl_q.go && !sp_q && sel_rise;
	endsequence

	sequence sp_close_s;
		gctl_q.spm && sp_q && sel_fall && !wr_gctl;
	endsequence

	off_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!tctl_q.on and cnt_quiet_s |=> $stable(cnt_q))
		else $error("count moved while timer off");

	gated_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		tctl_q.on && gctl_q.ge && !gate_level and cnt_quiet_s |=> $stable(cnt_q))
		else $error("count moved while gate inactive");

	wrap_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		inc && cnt_q == GST_CNT_MAX |=> ovf_q && cnt_q == 16'h0000)
		else $error("wrap did not set overflow flag");

	low_write_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_lo |=> cnt_q[7:0] == $past(wbyte_q) && $stable(cnt_q[15:8]))
		else $error("low byte write not applied");

	presc_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		wr_cnt |=> presc_q == 3'h0)
		else $error("prescaler not cleared by count write");

	toggle_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		!gctl_q.tm |=> !tog_q)
		else $error("toggle flop not held clear");

	ext_armed_a: assert property (@(posedge clk) disable iff (!resetn)
		inc && tctl_q.cs == GST_CS_EXT |-> ext_armed_q)
		else $error("external edge counted before falling edge");

	gate_fall_a: assert property (@(posedge clk) disable iff (!resetn)
		gval_q && !gate_level |=> gev_q)
		else $error("gate fall did not set event flag");

	pulse_open_a: assert property (@(posedge clk) disable iff (!resetn)
		sp_open_s |=> sp_q)
		else $error("single pulse window did not open");

	pulse_done_a: assert property (@(posedge clk) disable iff (!resetn)
		sp_close_s |=> !gctl_q.go && !sp_q)
		else $error("single pulse did not end with go cleared");

	pulse_idle_a: assert property (@(posedge clk) disable iff (!resetn)
		gctl_q.spm && !gctl_q.go && !sp_q |=> !sp_q)
		else $error("gate event counted after go cleared");

	sys_rate_a: assert property (@(posedge clk) disable iff (!resetn)
		(tctl_q.on && !gctl_q.ge && !sleep && tctl_q.cs == GST_CS_SYS && tctl_q.ps == 2'h0
			&& !wr_cnt && !wr_tctl && !wr_gctl)[*4]
		|=> cnt_q == $past(cnt_q, 4) + 16'h0004)
		else $error("system clock source did not advance four per instruction");

endmodule : gst_timer
`default_nettype wire

// [gst_pkg.sv]
// Shared constants and types for the gated sixteen-bit timer
package gst_pkg;

	// Register byte addresses on the AXI4-Lite bus
	localparam logic [7:0] GST_ADDR_CNT_LO = 8'h00;
	localparam logic [7:0] GST_ADDR_CNT_HI = 8'h04;
	localparam logic [7:0] GST_ADDR_TCTL = 8'h08;
	localparam logic [7:0] GST_ADDR_GCTL = 8'h0C;
	localparam logic [7:0] GST_ADDR_FLAG = 8'h10;

	// timer_control_reg field positions
	localparam int GST_TCTL_CS_LSB = 6;
	localparam int GST_TCTL_PS_LSB = 4;
	localparam int GST_TCTL_SYNCDIS = 2;
	localparam int GST_TCTL_ON = 0;

	// gate_control_reg field positions
	localparam int GST_GCTL_GE = 7;
	localparam int GST_GCTL_POL = 6;
	localparam int GST_GCTL_TM = 5;
	localparam int GST_GCTL_SPM = 4;
	localparam int GST_GCTL_GO = 3;
	localparam int GST_GCTL_VAL = 2;
	localparam int GST_GCTL_GSS_LSB = 0;

	// Flag register positions, write one to clear
	localparam int GST_FLAG_GEV = 1;
	localparam int GST_FLAG_OVF = 0;

	// Reset values
	localparam logic [15:0] GST_CNT_RST = 16'h0000;
	localparam logic [7:0] GST_TCTL_RST = 8'h00;
	localparam logic [7:0] GST_GCTL_RST = 8'h00;

	// clock_select_field codes
	localparam logic [1:0] GST_CS_INSTR = 2'h0;
	localparam logic [1:0] GST_CS_SYS = 2'h1;
	localparam logic [1:0] GST_CS_EXT = 2'h2;
	localparam logic [1:0] GST_CS_LFOSC = 2'h3;

	// gate_source_field codes
	localparam logic [1:0] GST_GSS_PIN = 2'h0;
	localparam logic [1:0] GST_GSS_COMP = 2'h1;

	// Timing: system clock period and instruction clock divide
	localparam int GST_CLK_PERIOD_NS = 100;
	localparam int GST_INSTR_DIV = 4;
	localparam logic [1:0] GST_INSTR_LAST = 2'(GST_INSTR_DIV - 1);
	localparam logic [15:0] GST_CNT_MAX = 16'hFFFF;

	// AXI responses
	localparam logic [1:0] GST_RESP_OKAY = 2'h0;
	localparam logic [1:0] GST_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] cs;
		logic [1:0] ps;
		logic sync_dis;
		logic on;
	} gst_tctl_s;

	typedef struct packed {
		logic ge;
		logic pol;
		logic tm;
		logic spm;
		logic go;
		logic [1:0] gss;
	} gst_gctl_s;

endpackage : gst_pkg

// [gst_ext_src.sv]
// Model of the external clock and gate signal source
`timescale 1ns/1ps
`default_nettype none
module gst_ext_src (
	input wire logic clk,
	output logic clk_pin,
	output logic gate_pin
);
	initial begin
		clk_pin = 1'b0;
		gate_pin = 1'b0;
	end

	// Clock stands low between bursts; each phase outlasts the pin synchroniser
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk);
			clk_pin <= 1'b1;
			repeat (4) @(posedge clk);
			clk_pin <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask : pulses

	task automatic set_gate(input logic v);
		@(posedge clk);
		gate_pin <= v;
	endtask : set_gate

	task automatic gate_pulse(input int h, input int l);
		set_gate(1'b1);
		repeat (h) @(posedge clk);
		set_gate(1'b0);
		repeat (l) @(posedge clk);
	endtask : gate_pulse
endmodule : gst_ext_src
`default_nettype wire

// [gst_timer_tb.sv]
// Self-checking testbench for the gated sixteen-bit timer
`timescale 1ns/1ps
`default_nettype none
module gst_timer_tb;
	import gst_pkg::*;
	typedef struct {
		logic [7:0] tctl;
		logic [7:0] gctl;
		logic gate;
		int cyc;
		int div;
		int slack;
	} gst_row_s;
	logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, ext_clk, ext_gate, lfosc, comp_pulse;
	logic sleep, overflow_flag, gate_event_flag, wake;
	logic wr_lane;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, last_data;
	logic [3:0] wstrb, comp_cnt;
	logic [4:0] osc_cnt;
	logic [1:0] bresp, rresp, last_resp;
	logic [15:0] cnt;
	int errors, num_checks, cycles, wakes, lo, hi;
	gst_row_s rows[13];

	gst_timer dut (.clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .external_clock_pin(ext_clk),
		.external_gate_pin(ext_gate), .low_freq_internal_osc(lfosc),
		.companion_timer_wrap_pulse(comp_pulse), .sleep(sleep),
		.overflow_flag(overflow_flag), .gate_event_flag(gate_event_flag), .wake(wake));
	gst_ext_src src (.clk(clk), .clk_pin(ext_clk), .gate_pin(ext_gate));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Slow oscillator of 32 cycles and a companion wrap every 16 cycles
	always @(posedge clk) begin
		osc_cnt <= osc_cnt + 5'h01;
		lfosc <= osc_cnt[4];
		comp_cnt <= comp_cnt + 4'h1;
		comp_pulse <= (comp_cnt == 4'hF);
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (wake === 1'b1) wakes <= wakes + 1;
		if (cycles == 60000) begin
			errors = errors + 1;
			summarize();
		end
	end

	function automatic logic [7:0] tc(input logic [1:0] cs, input logic [1:0] ps,
		input logic sd, input logic on);
		return {cs, ps, 1'b0, sd, 1'b0, on};
	endfunction : tc

	function automatic logic [7:0] gc(input logic ge, input logic pol, input logic tm,
		input logic spm, input logic go, input logic [1:0] gss);
		return {ge, pol, tm, spm, go, 1'b0, gss};
	endfunction : gc

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic check_range(input int l, input int h);
		check({31'h0, cnt >= l && cnt <= h}, 32'h1);
	endtask : check_range

	task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h00, d};
		wstrb <= {3'h7, wr_lane};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
		end while (bvalid !== 1'b1);
		last_resp = bresp;
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			arvalid <= arvalid && !arready;
		end while (rvalid !== 1'b1);
		last_data = rdata;
		last_resp = rresp;
		rready <= 1'b0;
	endtask : axi_read

	task automatic read_count();
		axi_read(GST_ADDR_CNT_LO);
		cnt[7:0] = last_data[7:0];
		axi_read(GST_ADDR_CNT_HI);
		cnt[15:8] = last_data[7:0];
	endtask : read_count

	task automatic clear_count();
		axi_write(GST_ADDR_CNT_LO, 8'h00);
		axi_write(GST_ADDR_CNT_HI, 8'h00);
	endtask : clear_count

	task automatic summarize();
		$display("Checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready, sleep} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{osc_cnt, comp_cnt, lfosc, comp_pulse} = 11'h000;
		{errors, num_checks, cycles, wakes} = {32'h0, 32'h0, 32'h0, 32'h0};
		wr_lane = 1'b1;
		rows = '{
			'{tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1), 8'h00, 1'b0, 200, 1, 2},
			'{tc(GST_CS_SYS, 2'h1, 1'b0, 1'b1), 8'h00, 1'b0, 200, 2, 2},
			'{tc(GST_CS_SYS, 2'h2, 1'b0, 1'b1), 8'h00, 1'b0, 400, 4, 2},
			'{tc(GST_CS_SYS, 2'h3, 1'b0, 1'b1), 8'h00, 1'b0, 400, 8, 2},
			'{tc(GST_CS_INSTR, 2'h0, 1'b0, 1'b1), 8'h00, 1'b0, 400, 4, 2},
			'{tc(GST_CS_LFOSC, 2'h0, 1'b0, 1'b1), 8'h00, 1'b0, 1600, 32, 2},
			'{tc(GST_CS_SYS, 2'h0, 1'b0, 1'b0), 8'h00, 1'b0, 200, 0, 0},
			'{tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1), gc(1, 1, 0, 0, 0, 0), 1'b0, 200, 0, 0},
			'{tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1), gc(1, 0, 0, 0, 0, 0), 1'b0, 200, 1, 2},
			'{tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1), gc(1, 0, 0, 0, 0, 0), 1'b1, 200, 0, 0},
			'{tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1), gc(1, 1, 0, 0, 0, 0), 1'b1, 200, 1, 2},
			'{tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1), gc(1, 1, 0, 0, 0, 1), 1'b0, 800, 16, 2},
			'{tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1), gc(1, 1, 1, 0, 0, 1), 1'b0, 800, 2, 10}
		};
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		axi_read(GST_ADDR_TCTL);
		check(last_data, {24'h0, GST_TCTL_RST});
		axi_read(GST_ADDR_GCTL);
		check(last_data & 32'hFFFFFFFB, {24'h0, GST_GCTL_RST});
		read_count();
		check({16'h0, cnt}, {16'h0, GST_CNT_RST});
		axi_read(8'h14);
		check({30'h0, last_resp}, {30'h0, GST_RESP_SLVERR});
		axi_write(8'h14, 8'hFF);
		check({30'h0, last_resp}, {30'h0, GST_RESP_SLVERR});
		foreach (rows[i]) begin
			src.set_gate(rows[i].gate);
			clear_count();
			axi_write(GST_ADDR_GCTL, rows[i].gctl);
			axi_write(GST_ADDR_TCTL, rows[i].tctl);
			repeat (rows[i].cyc) @(posedge clk);
			axi_write(GST_ADDR_TCTL, 8'h00);
			read_count();
			lo = (rows[i].div == 0) ? 0 : rows[i].cyc / rows[i].div - rows[i].slack;
			hi = (rows[i].div == 0) ? 0 : (rows[i].cyc + 12) / rows[i].div + rows[i].slack;
			check_range(lo, hi);
		end
		// External pin counting, synchronised and not; pin starts low
		axi_write(GST_ADDR_GCTL, 8'h00);
		for (int sd = 0; sd < 2; sd++) begin
			clear_count();
			axi_write(GST_ADDR_TCTL, tc(GST_CS_EXT, 2'h0, sd[0], 1'b1));
			src.pulses(5);
			axi_write(GST_ADDR_TCTL, 8'h00);
			read_count();
			check({16'h0, cnt}, 32'h4);
		end
		// Half-way prescaler must be discarded by a count write
		clear_count();
		axi_write(GST_ADDR_TCTL, tc(GST_CS_EXT, 2'h1, 1'b0, 1'b1));
		src.pulses(4);
		read_count();
		check({16'h0, cnt}, 32'h1);
		clear_count();
		src.pulses(2);
		read_count();
		check({16'h0, cnt}, 32'h0);
		src.pulses(1);
		read_count();
		check({16'h0, cnt}, 32'h1);
		axi_write(GST_ADDR_TCTL, 8'h00);
		// Byte writes and wrap
		axi_write(GST_ADDR_CNT_LO, 8'hFD);
		axi_write(GST_ADDR_CNT_HI, 8'hFF);
		read_count();
		check({16'h0, cnt}, 32'hFFFD);
		// Lane zero cleared: accepted but nothing written
		wr_lane = 1'b0;
		axi_write(GST_ADDR_CNT_LO, 8'h00);
		wr_lane = 1'b1;
		check({30'h0, last_resp}, {30'h0, GST_RESP_OKAY});
		read_count();
		check({16'h0, cnt}, 32'hFFFD);
		axi_write(GST_ADDR_TCTL, tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1));
		repeat (20) @(posedge clk);
		axi_write(GST_ADDR_TCTL, 8'h00);
		check({31'h0, overflow_flag}, 32'h1);
		read_count();
		check_range(15, 30);
		axi_write(GST_ADDR_FLAG, 8'h01);
		@(posedge clk);
		check({31'h0, overflow_flag}, 32'h0);
		// Asleep: only unsynchronised external counting runs and wakes
		axi_write(GST_ADDR_CNT_LO, 8'hFF);
		axi_write(GST_ADDR_CNT_HI, 8'hFF);
		@(posedge clk);
		sleep <= 1'b1;
		// System source must freeze in sleep, else the wrap checks below trip
		axi_write(GST_ADDR_TCTL, tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1));
		repeat (20) @(posedge clk);
		axi_write(GST_ADDR_TCTL, tc(GST_CS_EXT, 2'h0, 1'b1, 1'b1));
		src.pulses(3);
		@(posedge clk);
		sleep <= 1'b0;
		check(wakes, 32'h1);
		check({31'h0, overflow_flag}, 32'h1);
		axi_write(GST_ADDR_TCTL, 8'h00);
		read_count();
		check({16'h0, cnt}, 32'h1);
		// Gate status and event flag with gating off
		// Polarity change drops the level first, so clear flags after it
		axi_write(GST_ADDR_GCTL, gc(0, 1, 0, 0, 0, 0));
		axi_write(GST_ADDR_FLAG, 8'h03);
		src.set_gate(1'b1);
		repeat (8) @(posedge clk);
		axi_read(GST_ADDR_GCTL);
		check({31'h0, last_data[GST_GCTL_VAL]}, 32'h1);
		check({31'h0, gate_event_flag}, 32'h0);
		src.set_gate(1'b0);
		repeat (8) @(posedge clk);
		axi_read(GST_ADDR_GCTL);
		check({31'h0, last_data[GST_GCTL_VAL]}, 32'h0);
		check({31'h0, gate_event_flag}, 32'h1);
		// Single pulse: only the first gate pulse of 40 cycles counts
		axi_write(GST_ADDR_FLAG, 8'h03);
		clear_count();
		axi_write(GST_ADDR_GCTL, gc(1, 1, 0, 1, 0, 0));
		axi_write(GST_ADDR_GCTL, gc(1, 1, 0, 1, 1, 0));
		axi_write(GST_ADDR_TCTL, tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1));
		src.gate_pulse(40, 40);
		src.gate_pulse(40, 40);
		axi_write(GST_ADDR_TCTL, 8'h00);
		read_count();
		check_range(35, 46);
		axi_read(GST_ADDR_GCTL);
		check({31'h0, last_data[GST_GCTL_GO]}, 32'h0);
		check({31'h0, gate_event_flag}, 32'h1);
		// Toggle with single pulse: one full gate period of 60 cycles
		clear_count();
		axi_write(GST_ADDR_GCTL, gc(1, 1, 0, 1, 0, 0));
		axi_write(GST_ADDR_GCTL, gc(1, 1, 1, 1, 0, 0));
		axi_write(GST_ADDR_GCTL, gc(1, 1, 1, 1, 1, 0));
		axi_write(GST_ADDR_TCTL, tc(GST_CS_SYS, 2'h0, 1'b0, 1'b1));
		repeat (3) src.gate_pulse(30, 30);
		axi_write(GST_ADDR_TCTL, 8'h00);
		read_count();
		check_range(55, 66);
		axi_read(GST_ADDR_GCTL);
		check({31'h0, last_data[GST_GCTL_GO]}, 32'h0);
		axi_write(GST_ADDR_GCTL, 8'h00);
		summarize();
	end
endmodule : gst_timer_tb
`default_nettype wire
